/* File: core/amz_ofs_mem.sv */
`timescale 1ns/10ps

package amz_pkg;
    // widths of the front-end controls and the converter
    localparam int          GAIN_W     = 3;
    localparam int          NUM_GAIN   = 6;
    localparam logic [2:0]  GAIN_LAST  = 3'h5;
    localparam int          BW_W       = 2;
    localparam logic [1:0]  BW_LAST    = 2'h3;
    localparam int          ADC_W      = 12;
    localparam int          SMP_W      = 16;
    localparam logic [11:0] LOW_THR    = 12'h199;   // about a tenth of full scale
    // timing, in printed units, and derived cycle counts
    localparam int CLK_NS           = 4;
    localparam int SWITCH_SETTLE_US = 150;
    localparam int SETTLE_CYC_DEF   = (SWITCH_SETTLE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int SAMPLE_RATE_SPS  = 1500;
    localparam int SAMPLE_CYC_DEF   = 1000000000 / (SAMPLE_RATE_SPS * CLK_NS);
    localparam int CNT_W            = 18;
    // command characters of the serial link
    localparam logic [7:0] CH_GAIN  = 8'h56;
    localparam logic [7:0] CH_BW    = 8'h42;
    localparam logic [7:0] CH_ESC   = 8'h24;
    localparam logic [7:0] CH_POL   = 8'h43;
    localparam logic [7:0] CH_ZSET  = 8'h41;
    localparam logic [7:0] CH_ZCLR  = 8'h52;
    localparam logic [7:0] CH_TRIG  = 8'h54;
    localparam logic [7:0] CH_RUN   = 8'h53;
    localparam logic [7:0] CH_HALT  = 8'h50;
    localparam logic [7:0] CH_ONE   = 8'h31;
    localparam logic [7:0] CH_SIX   = 8'h36;
    localparam logic [7:0] CH_FOUR  = 8'h34;
    // register map and fields
    localparam int         AXI_AW     = 4;
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_SAMPLE = 4'h8;
    localparam logic [3:0] REG_OFFSET = 4'hc;
    localparam int         CTRL_AUTO  = 0;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLV   = 2'h2;
    // states of the sequencer and of the command parser
    typedef enum logic [2:0] {ST_IDLE, ST_ZSETTLE, ST_ZCONV, ST_MCONV, ST_MSEND} amz_st_e;
    typedef enum logic [1:0] {PF_NONE, PF_GAIN, PF_BW, PF_ESC} amz_pf_e;
endpackage : amz_pkg

module amz_ofs_mem #(
    parameter int DATA_W = 12,
    parameter int DEPTH  = 6,
    parameter int ADDR_W = 3
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] waddr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [ADDR_W-1:0] raddr,
    output logic      [DATA_W-1:0] rdata
);
    if (DEPTH < 1 || DEPTH > (1 << ADDR_W) || DATA_W < 1) begin : g_bad
        $error("amz_ofs_mem: depth does not fit the address width");
    end

    typedef struct packed {
        logic [DEPTH-1:0][DATA_W-1:0] mem;
        logic [DATA_W-1:0]            rd;
    } amz_mem_s;

    amz_mem_s s_reg, s_next;

    // read first, read data always from a register
    always_comb begin
        s_next = s_reg;
        if (we && 32'(waddr) < DEPTH) begin
            s_next.mem[waddr] = wdata;
        end
        s_next.rd = (32'(raddr) < DEPTH) ? s_reg.mem[raddr] : '0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata = s_reg.rd;
endmodule : amz_ofs_mem

/* File: core/amz_ctrl.sv */
`timescale 1ns/10ps
// Overview of operation
// - six gain ranges, command index one to six
// - polarity command inverts output and reported values
// - polarity line low normal, high inverted
// - four bandwidths chosen by index one to four
// - serial zero start begins nulling, clear ends it
// - zero-start line high begins nulling
// - zero-clear line high ends offset removal
// - busy line low during offset acquisition
// - busy line high again when nulling completes
// - store one offset per gain range
// - overloaded ranges invalid, skipped by autogain
// - offset line shows removed portion while nulling
// - measure with a 12-bit converter
// - trigger command takes one measurement
// - continuous mode streams at 1.5 kS/s
// - gain lines binary, 000 lowest to 101
// - bandwidth lines one-hot, all low full
// - parallel lines active from start, no enable
module amz_ctrl import amz_pkg::*; #(
    parameter int SETTLE_CYC = SETTLE_CYC_DEF,
    parameter int SAMPLE_CYC = SAMPLE_CYC_DEF
) (
    input  wire logic              clk,
    input  wire logic              rst,
    // serial command bytes and sample stream
    input  wire logic              rx_valid,
    output logic                   rx_ready,
    input  wire logic [7:0]        rx_data,
    output logic                   tx_valid,
    input  wire logic              tx_ready,
    output logic      [SMP_W-1:0]  tx_data,
    // converter
    output logic                   adc_start,
    input  wire logic              adc_done,
    input  wire logic [ADC_W-1:0]  adc_data,
    input  wire logic              adc_ovl,
    // parallel control pins
    input  wire logic [GAIN_W-1:0] par_gain,
    input  wire logic [2:0]        par_bw,
    input  wire logic              par_invert,
    input  wire logic              par_zero_start,
    input  wire logic              par_zero_clear,
    output logic      [GAIN_W-1:0] gain_sel,
    output logic      [2:0]        bw_sel,
    output logic                   invert,
    output logic                   zero_busy_n,
    output logic      [ADC_W-1:0]  zero_offset,
    // axi4-lite slave
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [AXI_AW-1:0] s_axi_awaddr,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic      [1:0]        s_axi_bresp,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [AXI_AW-1:0] s_axi_araddr,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic      [31:0]       s_axi_rdata,
    output logic      [1:0]        s_axi_rresp
);
    if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << CNT_W) || SAMPLE_CYC < 2 || SAMPLE_CYC >= (1 << CNT_W))
    begin : g_bad
        $error("amz_ctrl: cycle counts out of counter range");
    end

    typedef struct packed {
        logic [8:0]        syn1;     // gain, bw, invert, zstart, zclear
        logic [8:0]        syn2;
        logic [8:0]        prv;
        amz_st_e           st;
        amz_pf_e           pf;
        logic [GAIN_W-1:0] gain;
        logic [BW_W-1:0]   bw;
        logic              inv;
        logic              zero_on;
        logic              busy;
        logic [GAIN_W-1:0] idx;
        logic [CNT_W-1:0]  cnt;
        logic [CNT_W-1:0]  rcnt;
        logic              cont;
        logic              mreq;
        logic [NUM_GAIN-1:0] valid;
        logic              adc_go;
        logic              we;
        logic [ADC_W-1:0]  wdat;
        logic [GAIN_W-1:0] gain_out;
        logic [2:0]        bw_out;
        logic [ADC_W-1:0]  ofs_out;
        logic [SMP_W-1:0]  smp;
        logic              txv;
        logic              ag_step;
        logic              auto_en;
        logic              aw_got;
        logic              w_got;
        logic [AXI_AW-1:0] awaddr;
        logic [31:0]       wdata;
        logic              wstrb0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } amz_ctrl_s;

    amz_ctrl_s s_reg, s_next;
    logic [ADC_W-1:0] mem_rd;
    logic             zs_rise, zc_rise, ser_zs, ser_zc, zstart, zclear, ser_gain_ok;
    logic [NUM_GAIN-1:0] eff_valid;
    logic [SMP_W-1:0] diff;

    amz_ofs_mem #(.DATA_W(ADC_W), .DEPTH(NUM_GAIN), .ADDR_W(GAIN_W)) u_mem (
        .clk   (clk),
        .rst   (rst),
        .we    (s_reg.we),
        .waddr (s_reg.idx),
        .wdata (s_reg.wdat),
        .raddr (s_reg.gain_out),
        .rdata (mem_rd)
    );

    // edge detect reads only second and third flops, never the first
    assign zs_rise   = s_reg.syn2[1] & ~s_reg.prv[1];
    assign zc_rise   = s_reg.syn2[0] & ~s_reg.prv[0];
    assign eff_valid = s_reg.zero_on ? s_reg.valid : {NUM_GAIN{1'b1}};
    assign diff      = {{(SMP_W-ADC_W){1'b0}}, adc_data}
                     - {{(SMP_W-ADC_W){1'b0}}, (s_reg.zero_on ? mem_rd : {ADC_W{1'b0}})};

    always_comb begin
        s_next         = s_reg;
        s_next.adc_go  = 1'b0;
        s_next.we      = 1'b0;
        s_next.ag_step = 1'b0;
        ser_zs         = 1'b0;
        ser_zc         = 1'b0;
        ser_gain_ok    = 1'b0;
        // two-flop synchronisers, active straight out of reset
        s_next.syn1 = {par_gain, par_bw, par_invert, par_zero_start, par_zero_clear};
        s_next.syn2 = s_reg.syn1;
        s_next.prv  = s_reg.syn2;
        // parallel lines act on change, so serial settings persist between
        if (s_reg.syn2[8:6] != s_reg.prv[8:6] && s_reg.syn2[8:6] <= GAIN_LAST) begin
            s_next.gain = s_reg.syn2[8:6];
        end
        if (s_reg.syn2[5:3] != s_reg.prv[5:3]) begin
            if (s_reg.syn2[5:3] == 3'h0) s_next.bw = 2'h0;
            else if (s_reg.syn2[5:3] == 3'h1) s_next.bw = 2'h1;
            else if (s_reg.syn2[5:3] == 3'h2) s_next.bw = 2'h2;
            else if (s_reg.syn2[5:3] == 3'h4) s_next.bw = 2'h3;
        end
        if (s_reg.syn2[2] != s_reg.prv[2]) begin
            s_next.inv = s_reg.syn2[2];
        end
        // serial command parser, one byte per cycle
        if (rx_valid) begin
            s_next.pf = PF_NONE;
            case (s_reg.pf)
                PF_NONE: begin
                    if (rx_data == CH_GAIN) s_next.pf = PF_GAIN;
                    else if (rx_data == CH_BW) s_next.pf = PF_BW;
                    else if (rx_data == CH_ESC) s_next.pf = PF_ESC;
                    else if (rx_data == CH_TRIG) s_next.mreq = 1'b1;
                    else if (rx_data == CH_RUN) s_next.cont = 1'b1;
                    else if (rx_data == CH_HALT) s_next.cont = 1'b0;
                end
                PF_GAIN: begin
                    if (rx_data >= CH_ONE && rx_data <= CH_SIX) begin
                        ser_gain_ok = 1'b1;
                        s_next.gain = GAIN_W'(rx_data - CH_ONE);
                    end
                end
                PF_BW: begin
                    if (rx_data >= CH_ONE && rx_data <= CH_FOUR) begin
                        s_next.bw = BW_W'(rx_data - CH_ONE);
                    end
                end
                default: begin
                    if (rx_data == CH_POL) s_next.inv = ~s_next.inv;
                    ser_zs = (rx_data == CH_ZSET);
                    ser_zc = (rx_data == CH_ZCLR);
                end
            endcase
        end
        zstart = zs_rise | ser_zs;
        zclear = zc_rise | ser_zc;
        // continuous rate divider, one request per period
        if (s_reg.cont) begin
            if (s_reg.rcnt == CNT_W'(SAMPLE_CYC - 1)) begin
                s_next.rcnt = '0;
                s_next.mreq = 1'b1;
            end else begin
                s_next.rcnt = s_reg.rcnt + 1'b1;
            end
        end else begin
            s_next.rcnt = '0;
        end
        // sequencer; the converter has one owner at a time
        case (s_reg.st)
            ST_IDLE: begin
                if (zstart && !zclear) begin
                    s_next.st      = ST_ZSETTLE;
                    s_next.busy    = 1'b1;
                    s_next.zero_on = 1'b0;
                    s_next.idx     = '0;
                    s_next.cnt     = '0;
                end else if (s_reg.mreq) begin
                    // a request arriving in the launch cycle stays pending, set wins
                    s_next.mreq   = (rx_valid && s_reg.pf == PF_NONE && rx_data == CH_TRIG)
                                    || (s_reg.cont && s_reg.rcnt == CNT_W'(SAMPLE_CYC - 1));
                    s_next.adc_go = 1'b1;
                    s_next.st     = ST_MCONV;
                end
            end
            ST_ZSETTLE: begin
                // waits for the range switch to settle before sampling
                s_next.cnt = s_reg.cnt + 1'b1;
                if (s_reg.cnt == CNT_W'(SETTLE_CYC - 1)) begin
                    s_next.adc_go = 1'b1;
                    s_next.st     = ST_ZCONV;
                end
            end
            ST_ZCONV: begin
                if (adc_done) begin
                    s_next.we              = 1'b1;
                    s_next.wdat            = adc_data;
                    s_next.valid[s_reg.idx] = ~adc_ovl;
                    s_next.cnt             = '0;
                    if (s_reg.idx == GAIN_LAST) begin
                        s_next.zero_on = 1'b1;
                        s_next.busy    = 1'b0;
                        s_next.st      = ST_IDLE;
                    end else begin
                        s_next.idx = s_reg.idx + 1'b1;
                        s_next.st  = ST_ZSETTLE;
                    end
                end
            end
            ST_MCONV: begin
                if (adc_done) begin
                    s_next.smp = s_reg.inv ? (~diff + 1'b1) : diff;
                    s_next.txv = 1'b1;
                    s_next.st  = ST_MSEND;
                    // autogain steps one range, never into an invalid one
                    if (s_reg.auto_en) begin
                        if (adc_ovl && s_reg.gain != '0 && eff_valid[s_reg.gain - 1'b1]) begin
                            s_next.gain    = s_reg.gain - 1'b1;
                            s_next.ag_step = 1'b1;
                        end else if (!adc_ovl && adc_data < LOW_THR && s_reg.gain != GAIN_LAST
                                     && eff_valid[s_reg.gain + 1'b1]) begin
                            s_next.gain    = s_reg.gain + 1'b1;
                            s_next.ag_step = 1'b1;
                        end
                    end
                end
            end
            default: begin
                if (tx_ready) begin
                    s_next.txv = 1'b0;
                    s_next.st  = ST_IDLE;
                end
            end
        endcase
        // clear wins over start and aborts a running acquisition
        if (zclear) begin
            s_next.zero_on = 1'b0;
            s_next.valid   = {NUM_GAIN{1'b1}};
            if (s_reg.busy) begin
                s_next.busy = 1'b0;
                s_next.st   = ST_IDLE;
            end
        end
        // registered pin values
        s_next.gain_out = s_next.busy ? s_next.idx : s_next.gain;
        s_next.bw_out   = (s_next.bw == 2'h0) ? 3'h0 : 3'(1 << (s_next.bw - 1'b1));
        s_next.ofs_out  = s_reg.zero_on ? mem_rd : '0;
        // axi write: address and data in either order, then response
        if (s_axi_awvalid && !s_reg.aw_got && !s_reg.bvalid) begin
            s_next.aw_got = 1'b1;
            s_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_reg.w_got && !s_reg.bvalid) begin
            s_next.w_got  = 1'b1;
            s_next.wdata  = s_axi_wdata;
            s_next.wstrb0 = s_axi_wstrb[0];
        end
        if (s_reg.aw_got && s_reg.w_got) begin
            s_next.aw_got = 1'b0;
            s_next.w_got  = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp  = RESP_OKAY;
            if (s_reg.awaddr == REG_CTRL) begin
                if (s_reg.wstrb0) s_next.auto_en = s_reg.wdata[CTRL_AUTO];
            end else if (s_reg.awaddr != REG_STATUS && s_reg.awaddr != REG_SAMPLE
                         && s_reg.awaddr != REG_OFFSET) begin
                s_next.bresp = RESP_SLV;
            end
        end
        if (s_reg.bvalid && s_axi_bready) s_next.bvalid = 1'b0;
        // axi read: one outstanding, data from a register
        if (s_reg.rvalid && s_axi_rready) s_next.rvalid = 1'b0;
        if (s_axi_arvalid && !s_reg.rvalid) begin
            s_next.rvalid = 1'b1;
            s_next.rresp  = RESP_OKAY;
            s_next.rdata  = '0;
            if (s_axi_araddr == REG_CTRL) begin
                s_next.rdata[CTRL_AUTO] = s_reg.auto_en;
            end else if (s_axi_araddr == REG_STATUS) begin
                s_next.rdata[14:0] = {s_reg.valid, s_reg.cont, s_reg.busy, s_reg.zero_on,
                                      s_reg.inv, s_reg.bw, s_reg.gain_out};
            end else if (s_axi_araddr == REG_SAMPLE) begin
                s_next.rdata = {{(32-SMP_W){s_reg.smp[SMP_W-1]}}, s_reg.smp};
            end else if (s_axi_araddr == REG_OFFSET) begin
                s_next.rdata[ADC_W-1:0] = s_reg.ofs_out;
            end else begin
                s_next.rresp = RESP_SLV;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg       <= '0;
            s_reg.st    <= ST_IDLE;
            s_reg.pf    <= PF_NONE;
            s_reg.valid <= {NUM_GAIN{1'b1}};
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs
    assign rx_ready      = 1'b1;
    assign tx_valid      = s_reg.txv;
    assign tx_data       = s_reg.smp;
    assign adc_start     = s_reg.adc_go;
    assign gain_sel      = s_reg.gain_out;
    assign bw_sel        = s_reg.bw_out;
    assign invert        = s_reg.inv;
    assign zero_busy_n   = ~s_reg.busy;
    assign zero_offset   = s_reg.ofs_out;
    assign s_axi_awready = ~s_reg.aw_got & ~s_reg.bvalid;
    assign s_axi_wready  = ~s_reg.w_got & ~s_reg.bvalid;
    assign s_axi_bvalid  = s_reg.bvalid;
    assign s_axi_bresp   = s_reg.bresp;
    assign s_axi_arready = ~s_reg.rvalid;
    assign s_axi_rvalid  = s_reg.rvalid;
    assign s_axi_rdata   = s_reg.rdata;
    assign s_axi_rresp   = s_reg.rresp;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_gain_code: assert property (gain_sel <= GAIN_LAST)
        else $error("gain code above highest range");
    chk_gain_cmd: assert property (ser_gain_ok && !s_reg.busy && !zclear |=>
        ##1 gain_sel == $past(rx_data, 2) - CH_ONE)
        else $error("gain command not applied");
    chk_pol_cmd: assert property (rx_valid && s_reg.pf == PF_ESC && rx_data == CH_POL
        && s_reg.syn2[2] == s_reg.prv[2] |=> invert != $past(invert))
        else $error("polarity command did not toggle");
    chk_bw_onehot: assert property ($onehot0(bw_sel))
        else $error("bandwidth lines not one-hot");
    chk_busy_start: assert property (s_reg.st == ST_IDLE && zstart && !zclear |=> !zero_busy_n)
        else $error("busy not driven low on start");
    chk_busy_end: assert property ($rose(zero_busy_n) |-> s_reg.zero_on || $past(zclear))
        else $error("busy released without completion or clear");
    chk_ofs_valid: assert property (s_reg.st == ST_ZCONV && adc_done && !zclear
        |=> s_reg.we && s_reg.valid[$past(s_reg.idx)] == !$past(adc_ovl))
        else $error("offset not stored with validity");
    chk_clear_stop: assert property (zclear |=> !s_reg.zero_on && zero_busy_n)
        else $error("clear did not end nulling");
    chk_auto_valid: assert property (s_reg.ag_step |-> eff_valid[s_reg.gain])
        else $error("autogain chose an invalid range");
    chk_ofs_out: assert property (!s_reg.zero_on |=> zero_offset == '0)
        else $error("offset line active while nulling off");
    chk_rate: assert property (s_reg.cont && s_reg.rcnt == CNT_W'(SAMPLE_CYC - 1)
        |=> s_reg.mreq || s_reg.st == ST_MCONV)
        else $error("continuous request missed");

    cov_null_done: cover property (s_reg.busy ##1 !s_reg.busy && s_reg.zero_on);
    cov_bad_range: cover property (s_reg.zero_on && s_reg.valid != {NUM_GAIN{1'b1}});
    cov_stream:    cover property (s_reg.cont && tx_valid && tx_ready);
endmodule : amz_ctrl

/* File: tb/amz_far_model.sv */
`timescale 1ns/10ps
// converter and sample sink on the far side of the block
module amz_far_model import amz_pkg::*; (
    input  wire logic             clk,
    input  wire logic             adc_start,
    input  wire logic [ADC_W-1:0] code,
    input  wire logic             ovl,
    output logic                  adc_done,
    output logic      [ADC_W-1:0] adc_data,
    output logic                  adc_ovl,
    output logic                  tx_ready
);
    logic [2:0] cnt = 3'h0;
    initial {adc_done, adc_data, adc_ovl, tx_ready} = '0;
    // slow conversion; data scrambled outside the done pulse
    always @(posedge clk) begin
        cnt      <= adc_start ? 3'h3 : cnt - 3'(cnt != 3'h0);
        adc_done <= (cnt == 3'h1);
        adc_data <= (cnt == 3'h1) ? code : ~adc_data;
        adc_ovl  <= (cnt == 3'h1) & ovl;  // overload flagged with the done pulse
        tx_ready <= ~tx_ready;  // sink stalls every other cycle
    end
endmodule : amz_far_model

/* File: tb/tb_amplifier_control_autozero.sv */
`timescale 1ns/10ps
module tb_amplifier_control_autozero import amz_pkg::*;;
    logic        clk, rst, rx_valid, tx_valid, tx_ready, adc_start, adc_done, adc_ovl;
    logic        par_invert, par_zero_start, par_zero_clear, invert, zero_busy_n, rx_ready;
    logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic [7:0]  rx_data;
    logic [2:0]  par_gain, par_bw, gain_sel, bw_sel;
    logic [3:0]  awa, ara;
    logic [31:0] wd, rd, d;
    logic [1:0]  bresp, rresp, r;
    logic [11:0] adc_data, zero_offset;
    logic [15:0] tx_data, s;
    int          miscompares = 0;
    int          compares = 0;
    amz_ctrl #(.SETTLE_CYC(4), .SAMPLE_CYC(20)) amz_ctrl_i (.clk, .rst, .rx_valid, .rx_ready, .rx_data,
        .tx_valid, .tx_ready, .tx_data, .adc_start, .adc_done, .adc_data, .adc_ovl, .par_gain, .par_bw,
        .par_invert, .par_zero_start, .par_zero_clear, .gain_sel, .bw_sel, .invert, .zero_busy_n,
        .zero_offset, .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp));
    // highest range overloads while offsets are captured
    amz_far_model amz_far_model_i (.clk, .adc_start, .code(12'h123), .ovl(!zero_busy_n && gain_sel == 3'h5),
        .adc_done, .adc_data, .adc_ovl, .tx_ready);
    // 4 ns clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // watchdog, well beyond the expected run
    initial begin
        #100000;
        miscompares++;
        wrap_up();
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    // two command bytes back to back, then time for the settings to land
    task automatic send(input logic [7:0] a, input logic [7:0] b);
        rx_valid <= 1'b1;
        rx_data  <= a;
        @(posedge clk);
        rx_data  <= b;
        @(posedge clk);
        rx_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : send
    task automatic grab();
        do @(posedge clk); while (!(tx_valid && tx_ready));
        s = tx_data;
    endtask : grab
    // bus write: address and data offered together, each dropped when taken
    task automatic axw(input logic [3:0] a);
        {awv, wv, br, awa, wd} <= {3'h7, a, 32'h1};
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv);
        r = bresp;
        br <= 1'b0;
    endtask : axw
    task automatic axr(input logic [3:0] a);
        {arv, rr, ara} <= {2'h3, a};
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        {d, r} = {rd, rresp};
        rr <= 1'b0;
    endtask : axr
    // reset, then every scenario in turn
    initial begin
        {rx_valid, rx_data, par_gain, par_bw, par_invert, par_zero_start, par_zero_clear} = '0;
        {awv, awa, wv, wd, br, arv, ara, rr} = '0;
        rst = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check({gain_sel, bw_sel, invert, zero_busy_n, rx_ready}, 9'h003);
        for (int i = 0; i < 6; i++) begin
            send(CH_GAIN, CH_ONE + 8'(i));
            check(gain_sel, i);
        end
        for (int i = 0; i < 4; i++) begin
            send(CH_BW, CH_ONE + 8'(i));
            check(bw_sel, (i == 0) ? 0 : 1 << (i - 1));
        end
        {par_gain, par_bw, par_invert} <= 7'h49;
        repeat (5) @(posedge clk);
        check({gain_sel, bw_sel, invert}, 7'h49);
        par_invert <= 1'b0;
        repeat (5) @(posedge clk);
        check(invert, 0);
        send(CH_ESC, CH_POL);
        send(CH_TRIG, 8'h00);
        grab();
        check(s, 16'hfedd);
        send(CH_ESC, CH_POL);
        $display("settings and measurement done");
        send(CH_ESC, CH_ZSET); // output positive here
        check(zero_busy_n, 0);
        do @(posedge clk); while (!zero_busy_n);
        // offset line follows the stored word two cycles after busy ends
        repeat (2) @(posedge clk);
        check({gain_sel, zero_offset}, 15'h4123);
        axr(REG_STATUS);
        check({d[14:9], d[6], r}, 9'h0fc);
        axw(REG_CTRL);
        check(r, RESP_OKAY);
        send(CH_TRIG, 8'h00);
        grab();
        check(s, 0);
        check(gain_sel, 3'h4);
        par_zero_clear <= 1'b1;
        repeat (5) @(posedge clk);
        check(zero_offset, 0);
        {par_zero_clear, par_zero_start} <= 2'h1;
        repeat (5) @(posedge clk);
        check(zero_busy_n, 0);
        send(CH_ESC, CH_ZCLR);
        check({zero_busy_n, zero_offset}, 13'h1000);
        $display("offset nulling done");
        axw(4'h2);
        check(r, RESP_SLV);
        send(CH_RUN, 8'h00);
        grab();
        for (int n = 1; n < 40; n++) begin
            @(posedge clk);
            if ((tx_valid && tx_ready) || n == 39) begin
                check(n >= 19 && n <= 21, 1);
                break;
            end
        end
        send(CH_HALT, 8'h00);
        axr(REG_SAMPLE);
        check({d, r}, {32'h123, RESP_OKAY});
        $display("bus and stream done");
        wrap_up();
    end
endmodule : tb_amplifier_control_autozero
